// ---- event_transfer_engine.sv ----
// event transfer engine: activation, descriptor fetch, transfer, write-back
`default_nettype none
module event_transfer_engine (
   input  wire logic              REF_CLK,
   input  wire logic              SYS_RST,
   input  wire xfer_pkg::reg_req_t REG_REQ,
   output logic [31:0]            REG_RDATA,
   input  wire logic [127:0]      IRQ_REQ,
   output logic [127:0]           SRC_CLR,
   output logic                   IRQ_FWD,
   output logic                   IRQ_FWD_SOFT,
   output logic [6:0]             IRQ_FWD_VEC,
   output xfer_pkg::mem_req_t     MEM_REQ,
   input  wire logic [31:0]       MEM_RDATA,
   output logic                   BUSY
);

   xfer_pkg::core_t r_reg;
   xfer_pkg::core_t r_next;
   logic [127:0]    pend;

   function automatic logic [6:0] lowest_vec(input logic [127:0] p);
      logic [6:0] v;
      v = '0;
      for (int i = 127; i >= 0; i--) begin
         if (p[i]) begin
            v = 7'(i);
         end
      end
      return v;
   endfunction

   function automatic logic [23:0] adv(input logic [23:0] a,
                                       input logic [1:0]  sm,
                                       input logic        sz);
      logic [23:0] s;
      s = sz ? 24'h000002 : 24'h000001;
      if (sm == xfer_pkg::AM_INC) begin
         return a + s;
      end
      if (sm == xfer_pkg::AM_DEC) begin
         return a - s;
      end
      return a;
   endfunction

   // undo a whole area of n units
   function automatic logic [23:0] rewind(input logic [23:0] a,
                                          input logic [1:0]  sm,
                                          input logic        sz,
                                          input logic [8:0]  n);
      logic [23:0] d;
      d = {15'h0000, n} << sz;
      if (sm == xfer_pkg::AM_INC) begin
         return a - d;
      end
      if (sm == xfer_pkg::AM_DEC) begin
         return a + d;
      end
      return a;
   endfunction

   // interrupt mask and controller priority are not inputs at all
   assign pend = IRQ_REQ & r_reg.en;

   always_comb begin
      logic [23:0] sa;
      logic [23:0] da;
      logic [8:0]  bsz;
      logic [1:0]  md;
      logic        dts;
      logic        sz;
      logic        irq_out;
      logic [15:0] cnt;
      logic [7:0]  cl;
      sa      = adv(r_reg.source_address_field, r_reg.mode_word_a[xfer_pkg::MRA_SM +: 2],
                    r_reg.mode_word_a[xfer_pkg::MRA_SZ]);
      da      = adv(r_reg.destination_address_field, r_reg.mode_word_a[xfer_pkg::MRA_DM +: 2],
                    r_reg.mode_word_a[xfer_pkg::MRA_SZ]);
      bsz     = {r_reg.count_word_a[15:8] == 8'h00, r_reg.count_word_a[15:8]};
      md      = r_reg.mode_word_a[xfer_pkg::MRA_MD +: 2];
      dts     = r_reg.mode_word_a[xfer_pkg::MRA_DTS];
      sz      = r_reg.mode_word_a[xfer_pkg::MRA_SZ];
      irq_out = r_reg.mode_word_b[xfer_pkg::MRB_PER_TRANSFER_IRQ_SELECT] | r_reg.ended;
      cnt     = r_reg.count_word_a - 16'h0001;
      cl      = r_reg.count_word_a[7:0] - 8'h01;
      r_next         = r_reg;
      r_next.mem.re  = 1'b0;
      r_next.mem.we  = 1'b0;
      r_next.src_clr = '0;
      r_next.fwd     = 1'b0;
      r_next.fin     = 1'b0;
      r_next.rdata   = '0;
      unique case (r_reg.st)
         xfer_pkg::S_IDLE: begin
            if (r_reg.fin) begin
               // one idle cycle lets a cleared peripheral drop its request
               r_next.st = xfer_pkg::S_IDLE;
            end else if (r_reg.soft_pend) begin
               r_next.soft_pend = 1'b0;
               r_next.cur_soft  = 1'b1;
               r_next.cur_vec   = r_reg.soft_vec;
               r_next.st        = xfer_pkg::S_VEC;
            end else if (|pend) begin
               r_next.cur_soft  = 1'b0;
               r_next.cur_vec   = lowest_vec(pend);
               r_next.st        = xfer_pkg::S_VEC;
            end
         end
         xfer_pkg::S_VEC: begin
            // entry address: offset + 0x400 + 2 * vector
            r_next.mem.addr = r_reg.vector_offset_register + xfer_pkg::VEC_BASE +
                              {16'h0000, r_reg.cur_vec, 1'b0};
            r_next.mem.size = xfer_pkg::SZ_WORD;
            r_next.mem.re   = 1'b1;
            r_next.st       = xfer_pkg::S_VEC_WT;
         end
         xfer_pkg::S_VEC_WT: begin
            r_next.st = xfer_pkg::S_VEC_TK;
         end
         xfer_pkg::S_VEC_TK: begin
            r_next.desc = {xfer_pkg::DESC_HI, MEM_RDATA[15:0]};
            r_next.idx  = 2'h0;
            r_next.st   = xfer_pkg::S_DSC;
         end
         xfer_pkg::S_DSC: begin
            r_next.mem.addr = r_reg.desc + {20'h00000, r_reg.idx, 2'b00};
            r_next.mem.size = xfer_pkg::SZ_LONG;
            r_next.mem.re   = 1'b1;
            r_next.st       = xfer_pkg::S_DSC_WT;
         end
         xfer_pkg::S_DSC_WT: begin
            r_next.st = xfer_pkg::S_DSC_TK;
         end
         xfer_pkg::S_DSC_TK: begin
            // mode a, source, mode b, destination, counts
            unique case (r_reg.idx)
               2'h0: {r_next.mode_word_a, r_next.source_address_field} = MEM_RDATA;
               2'h1: {r_next.mode_word_b, r_next.destination_address_field} = MEM_RDATA;
               default: {r_next.count_word_a, r_next.count_word_b} = MEM_RDATA;
            endcase
            if (r_reg.idx == 2'h2) begin
               r_next.ucnt = (md == xfer_pkg::MD_BLOCK) ?
                  {MEM_RDATA[31:24] == 8'h00, MEM_RDATA[31:24]} :
                  9'h001;
               r_next.st   = xfer_pkg::S_RD;
            end else begin
               r_next.idx = r_reg.idx + 2'h1;
               r_next.st  = xfer_pkg::S_DSC;
            end
         end
         xfer_pkg::S_RD: begin
            r_next.mem.addr = r_reg.source_address_field;
            r_next.mem.size = {1'b0, sz};
            r_next.mem.re   = 1'b1;
            r_next.st       = xfer_pkg::S_RD_WT;
         end
         xfer_pkg::S_RD_WT: begin
            r_next.st = xfer_pkg::S_WR;
         end
         xfer_pkg::S_WR: begin
            // read data stands only now, so it goes straight to the write
            r_next.mem.addr  = r_reg.destination_address_field;
            r_next.mem.wdata = {16'h0000, MEM_RDATA[15:0]};
            r_next.mem.size  = {1'b0, sz};
            r_next.mem.we    = 1'b1;
            r_next.source_address_field       = sa;
            r_next.destination_address_field       = da;
            r_next.ucnt      = r_reg.ucnt - 9'h001;
            r_next.idx       = 2'h0;
            r_next.st        = xfer_pkg::S_WB;
            unique case (md)
               xfer_pkg::MD_REPEAT: begin
                  r_next.ended = 1'b0;
                  r_next.count_word_a   = {r_reg.count_word_a[15:8], cl};
                  if (cl == 8'h00) begin
                     r_next.count_word_a[7:0] = r_reg.count_word_a[15:8];
                     if (dts) begin
                        r_next.source_address_field = rewind(sa,
                           r_reg.mode_word_a[xfer_pkg::MRA_SM +: 2], sz, bsz);
                     end else begin
                        r_next.destination_address_field = rewind(da,
                           r_reg.mode_word_a[xfer_pkg::MRA_DM +: 2], sz, bsz);
                     end
                  end
               end
               xfer_pkg::MD_BLOCK: begin
                  if (r_reg.ucnt > 9'h001) begin
                     r_next.st = xfer_pkg::S_RD;
                  end else begin
                     // only the block side returns to its start
                     if (dts) begin
                        r_next.source_address_field = rewind(sa,
                           r_reg.mode_word_a[xfer_pkg::MRA_SM +: 2], sz, bsz);
                     end else begin
                        r_next.destination_address_field = rewind(da,
                           r_reg.mode_word_a[xfer_pkg::MRA_DM +: 2], sz, bsz);
                     end
                     r_next.count_word_b   = r_reg.count_word_b - 16'h0001;
                     r_next.ended = (r_reg.count_word_b == 16'h0001);
                  end
               end
               default: begin
                  r_next.count_word_a   = cnt;
                  r_next.ended = (cnt == 16'h0000);
               end
            endcase
         end
         xfer_pkg::S_WB: begin
            r_next.mem.addr = r_reg.desc + {20'h00000, r_reg.idx, 2'b00};
            r_next.mem.size = xfer_pkg::SZ_LONG;
            r_next.mem.we   = 1'b1;
            unique case (r_reg.idx)
               2'h0: r_next.mem.wdata = {r_reg.mode_word_a, r_reg.source_address_field};
               2'h1: r_next.mem.wdata = {r_reg.mode_word_b, r_reg.destination_address_field};
               default: r_next.mem.wdata = {r_reg.count_word_a, r_reg.count_word_b};
            endcase
            r_next.st = xfer_pkg::S_WB_NX;
         end
         xfer_pkg::S_WB_NX: begin
            if (r_reg.idx != 2'h2) begin
               r_next.idx = r_reg.idx + 2'h1;
               r_next.st  = xfer_pkg::S_WB;
            end else if (r_reg.mode_word_b[xfer_pkg::MRB_CHNE]) begin
               r_next.desc = r_reg.desc + xfer_pkg::DESC_BYTES;
               r_next.idx  = 2'h0;
               r_next.st   = xfer_pkg::S_DSC;
            end else begin
               r_next.fin      = 1'b1;
               r_next.st       = xfer_pkg::S_IDLE;
               r_next.fwd_soft = r_reg.cur_soft;
               if (r_reg.cur_soft) begin
                  r_next.soft_flag = irq_out;
                  r_next.fwd       = irq_out;
               end else if (irq_out) begin
                  r_next.en[r_reg.cur_vec] = 1'b0;
                  r_next.fwd               = 1'b1;
               end else begin
                  r_next.src_clr[r_reg.cur_vec] = 1'b1;
               end
            end
         end
      endcase
      // software writes come last so a set in a clearing cycle survives
      // enable bit index is the vector, so 109 is word 3 bit 13
      if (REG_REQ.we) begin
         if (REG_REQ.addr[7:4] == 4'h0) begin
            r_next.en[{REG_REQ.addr[3:2], 5'h00} +: 32] = REG_REQ.wdata;
         end else if (REG_REQ.addr == xfer_pkg::REG_SOFT) begin
            r_next.soft_flag = REG_REQ.wdata[xfer_pkg::SOFT_FLAG_BIT];
            r_next.soft_pend = REG_REQ.wdata[xfer_pkg::SOFT_FLAG_BIT];
            r_next.soft_vec  = REG_REQ.wdata[6:0];
         end else if (REG_REQ.addr == xfer_pkg::REG_VECTOR_OFFSET_REGISTER) begin
            r_next.vector_offset_register = REG_REQ.wdata[23:0];
         end
      end
      if (REG_REQ.re) begin
         if (REG_REQ.addr[7:4] == 4'h0) begin
            r_next.rdata = r_reg.en[{REG_REQ.addr[3:2], 5'h00} +: 32];
         end else if (REG_REQ.addr == xfer_pkg::REG_SOFT) begin
            r_next.rdata = {24'h000000, r_reg.soft_flag, r_reg.soft_vec};
         end else if (REG_REQ.addr == xfer_pkg::REG_VECTOR_OFFSET_REGISTER) begin
            r_next.rdata = {8'h00, r_reg.vector_offset_register};
         end else if (REG_REQ.addr == xfer_pkg::REG_STAT) begin
            r_next.rdata = {17'h00000, r_reg.cur_vec, 6'h00,
                            r_reg.cur_soft, r_reg.st != xfer_pkg::S_IDLE};
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         r_reg <= xfer_pkg::CORE_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign REG_RDATA    = r_reg.rdata;
   assign SRC_CLR      = r_reg.src_clr;
   assign IRQ_FWD      = r_reg.fwd;
   assign IRQ_FWD_SOFT = r_reg.fwd_soft;
   assign IRQ_FWD_VEC  = r_reg.cur_vec;
   assign MEM_REQ      = r_reg.mem;
   assign BUSY         = (r_reg.st != xfer_pkg::S_IDLE);

   chk_soft_first: assert property (
      @(posedge REF_CLK) disable iff (SYS_RST)
      (r_reg.st == xfer_pkg::S_IDLE && !r_reg.fin && r_reg.soft_pend)
      |=> (r_reg.st == xfer_pkg::S_VEC && r_reg.cur_soft))
      else $error("software activation not served first");

   chk_irq_order: assert property (
      @(posedge REF_CLK) disable iff (SYS_RST)
      (r_reg.st == xfer_pkg::S_IDLE && !r_reg.fin && !r_reg.soft_pend
       && |pend)
      |=> (r_reg.cur_vec == lowest_vec($past(pend)) && !r_reg.cur_soft))
      else $error("request not served in vector order");

   chk_vec_fetch: assert property (
      @(posedge REF_CLK) disable iff (SYS_RST)
      (r_reg.st == xfer_pkg::S_VEC)
      |=> (MEM_REQ.re && MEM_REQ.addr == r_reg.vector_offset_register + xfer_pkg::VEC_BASE
           + {16'h0000, r_reg.cur_vec, 1'b0}) ##2
          (r_reg.st == xfer_pkg::S_DSC && r_reg.idx == 2'h0))
      else $error("vector entry fetch wrong");

   chk_desc_long: assert property (
      @(posedge REF_CLK) disable iff (SYS_RST)
      ((r_reg.st == xfer_pkg::S_DSC_WT || r_reg.st == xfer_pkg::S_WB_NX)
       && (MEM_REQ.re || MEM_REQ.we))
      |-> (MEM_REQ.size == xfer_pkg::SZ_LONG
           && MEM_REQ.addr[1:0] == 2'b00))
      else $error("descriptor access not one long word");

   chk_soft_clear: assert property (
      @(posedge REF_CLK) disable iff (SYS_RST)
      (r_reg.fin && r_reg.fwd_soft && !r_reg.fwd && !$past(REG_REQ.we))
      |-> !r_reg.soft_flag)
      else $error("software flag kept after quiet transfer");

   chk_fwd_enable: assert property (
      @(posedge REF_CLK) disable iff (SYS_RST)
      (r_reg.fwd && !r_reg.fwd_soft && !$past(REG_REQ.we))
      |-> (!r_reg.en[r_reg.cur_vec] && SRC_CLR == '0))
      else $error("enable not dropped on forwarded interrupt");

   chk_clr_pulse: assert property (
      @(posedge REF_CLK) disable iff (SYS_RST)
      (|r_reg.src_clr)
      |-> (r_reg.src_clr == (128'h1 << r_reg.cur_vec) && !r_reg.fwd)
          ##1 (r_reg.src_clr == '0))
      else $error("source clear not a single one-cycle pulse");

   chk_repeat_live: assert property (
      @(posedge REF_CLK) disable iff (SYS_RST)
      (r_reg.st == xfer_pkg::S_WB
       && r_reg.mode_word_a[xfer_pkg::MRA_MD +: 2] == xfer_pkg::MD_REPEAT)
      |-> ((r_reg.count_word_a[7:0] != 8'h00 || r_reg.count_word_a[15:8] == 8'h00)
           && !r_reg.ended))
      else $error("repeat count not reloaded");

   chk_block_size: assert property (
      @(posedge REF_CLK) disable iff (SYS_RST)
      (r_reg.st == xfer_pkg::S_RD
       && r_reg.mode_word_a[xfer_pkg::MRA_MD +: 2] == xfer_pkg::MD_BLOCK)
      |-> (r_reg.ucnt >= 9'h001 && r_reg.ucnt <= 9'h100))
      else $error("block unit count out of range");
endmodule // event_transfer_engine
`default_nettype wire

// ---- xfer_pkg.sv ----
// shared constants and types of the event transfer engine
`default_nettype none
package xfer_pkg;
   localparam int          NUM_VEC     = 128;
   // vector table and descriptor placement
   localparam logic [23:0] VEC_BASE    = 24'h000400;
   localparam logic [7:0]  DESC_HI     = 8'hFF;
   localparam logic [23:0] DESC_BYTES  = 24'h00000C;
   localparam logic [6:0]  TIMER_G_MATCH_A_VEC = 7'h6D;
   // register offsets, byte addresses on the register port
   localparam logic [7:0]  REG_EN0     = 8'h00;
   localparam logic [7:0]  REG_EN1     = 8'h04;
   localparam logic [7:0]  REG_EN2     = 8'h08;
   localparam logic [7:0]  REG_EN3     = 8'h0C;
   localparam logic [7:0]  REG_SOFT    = 8'h10;
   localparam logic [7:0]  REG_VECTOR_OFFSET_REGISTER    = 8'h14;
   localparam logic [7:0]  REG_STAT    = 8'h18;
   localparam int          SOFT_FLAG_BIT = 7;
   // descriptor mode word fields
   localparam int          MRA_SM      = 6;
   localparam int          MRA_DM      = 4;
   localparam int          MRA_MD      = 2;
   localparam int          MRA_DTS     = 1;
   localparam int          MRA_SZ      = 0;
   localparam int          MRB_CHNE    = 7;
   localparam int          MRB_PER_TRANSFER_IRQ_SELECT   = 6;
   localparam logic [1:0]  MD_NORMAL   = 2'h0;
   localparam logic [1:0]  MD_REPEAT   = 2'h1;
   localparam logic [1:0]  MD_BLOCK    = 2'h2;
   localparam logic [1:0]  AM_INC      = 2'h2;
   localparam logic [1:0]  AM_DEC      = 2'h3;
   // memory access sizes
   localparam logic [1:0]  SZ_BYTE     = 2'h0;
   localparam logic [1:0]  SZ_WORD     = 2'h1;
   localparam logic [1:0]  SZ_LONG     = 2'h2;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        we;
      logic        re;
   } reg_req_t;

   typedef struct packed {
      logic [23:0] addr;
      logic [31:0] wdata;
      logic        re;
      logic        we;
      logic [1:0]  size;
   } mem_req_t;

   typedef enum logic [11:0] {
      S_IDLE   = 12'h001,
      S_VEC    = 12'h002,
      S_VEC_WT = 12'h004,
      S_VEC_TK = 12'h008,
      S_DSC    = 12'h010,
      S_DSC_WT = 12'h020,
      S_DSC_TK = 12'h040,
      S_RD     = 12'h080,
      S_RD_WT  = 12'h100,
      S_WR     = 12'h200,
      S_WB     = 12'h400,
      S_WB_NX  = 12'h800
   } state_t;

   typedef struct packed {
      state_t       st;
      logic         fin;
      logic [127:0] en;
      logic         soft_flag;
      logic         soft_pend;
      logic [6:0]   soft_vec;
      logic [23:0]  vector_offset_register;
      logic [31:0]  rdata;
      logic         cur_soft;
      logic [6:0]   cur_vec;
      logic [23:0]  desc;
      logic [1:0]   idx;
      logic [7:0]   mode_word_a;
      logic [23:0]  source_address_field;
      logic [7:0]   mode_word_b;
      logic [23:0]  destination_address_field;
      logic [15:0]  count_word_a;
      logic [15:0]  count_word_b;
      logic [8:0]   ucnt;
      logic         ended;
      mem_req_t     mem;
      logic [127:0] src_clr;
      logic         fwd;
      logic         fwd_soft;
   } core_t;

   localparam core_t CORE_RESET = '{st: S_IDLE, default: '0};
endpackage
`default_nettype wire

// ---- mem_model.sv ----
// memory and peripheral flag model facing the transfer engine
`default_nettype none
module mem_model (
   input  wire logic               clk,
   input  wire xfer_pkg::mem_req_t req,
   input  wire logic [127:0]       clr,
   output logic [31:0]             rdata,
   output logic [127:0]            flags
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] m [logic [23:0]];
   initial begin
      rdata = 32'h0;
      flags = '0;
   end
   task automatic raise(input int v);
      flags[v] <= 1'b1;
   endtask
   task automatic drop(input int v);
      flags[v] <= 1'b0;
   endtask
   // big-endian, so the mode byte sits lowest
   function automatic logic [31:0] get(input logic [23:0] a, input int n);
      logic [31:0] d;
      d = '0;
      for (int i = 0; i < n; i++) d = {d[23:0], m[a + 24'(i)]};
      return d;
   endfunction
   task automatic put(input logic [23:0] a, input logic [31:0] dt,
                      input int n);
      for (int i = 0; i < n; i++) m[a + 24'(i)] = dt[8 * (n - 1 - i) +: 8];
   endtask
   always @(posedge clk) begin
      // data only in the cycle after the strobe, toggled otherwise so a
      // late sample can never match by luck
      if (req.re === 1'b1) rdata <= get(req.addr, 1 << req.size);
      else rdata <= ~rdata;
      if (req.we === 1'b1) put(req.addr, req.wdata, 1 << req.size);
      // a cleared peripheral drops its request one cycle later
      for (int i = 0; i < 128; i++) if (clr[i]) flags[i] <= 1'b0;
   end
endmodule // mem_model
`default_nettype wire

// ---- event_transfer_engine_test.sv ----
// self-checking bench of the event transfer engine
`default_nettype none
module event_transfer_engine_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic               clk, rst, fwd, fsoft, busy;
   xfer_pkg::reg_req_t rq;
   xfer_pkg::mem_req_t mreq;
   logic [31:0]        rdat, mdat, rng, d;
   logic [127:0]       irq, clr;
   logic [6:0]         fvec, v;
   logic [31:0]        evq [$];
   int                 fails, num_checks;

   event_transfer_engine DUT (.REF_CLK(clk), .SYS_RST(rst), .REG_REQ(rq),
      .REG_RDATA(rdat), .IRQ_REQ(irq), .SRC_CLR(clr), .IRQ_FWD(fwd),
      .IRQ_FWD_SOFT(fsoft), .IRQ_FWD_VEC(fvec), .MEM_REQ(mreq),
      .MEM_RDATA(mdat), .BUSY(busy));
   mem_model u_mem (.clk(clk), .req(mreq), .clr(clr), .rdata(mdat),
      .flags(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // vector entry address, offset plus base plus twice the number
   function automatic logic [23:0] vad(input logic [23:0] o,
                                       input logic [6:0] n);
      return o + 24'h000400 + {16'h0, n, 1'b0};
   endfunction
   task automatic rnd(output logic [31:0] r);
      rng = xs(rng);
      r = rng;
   endtask
   task automatic check(input string n, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dt);
      @(posedge clk);
      rq <= '{addr: a, wdata: dt, we: 1'b1, re: 1'b0};
      @(posedge clk);
      rq <= '0;
   endtask
   task automatic rchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
      @(posedge clk);
      rq <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge clk);
      rq <= '0;
      #1 check(n, rdat, e);
   endtask
   // descriptors on four-byte boundaries, fields in order
   task automatic desc(input logic [23:0] a, input logic [7:0] ma, mb,
                       input logic [23:0] s, t, input logic [15:0] ca, cb);
      u_mem.put(a, {ma, s}, 4);
      u_mem.put(a + 24'h4, {mb, t}, 4);
      u_mem.put(a + 24'h8, {ca, cb}, 4);
   endtask
   task automatic wait_ev(input int n);
      int k;
      k = 0;
      // let the engine leave idle, then wait for the events and the end
      repeat (4) @(negedge clk);
      while ((evq.size() < n || busy !== 1'b0) && k < 20000) begin
         @(negedge clk);
         k++;
      end
      if (k >= 20000) begin
         fails++;
         test_done;
      end
      repeat (4) @(negedge clk);
      check("event count", evq.size(), n);
   endtask

   // completions seen at the pins, in the order they happen
   always @(posedge clk) begin
      if (fwd === 1'b1) evq.push_back({22'h0, 2'h2, fsoft, fvec});
      if (|clr) begin
         evq.push_back({22'h0, 2'h1, 1'b0, fvec});
         check("one hot", 32'(clr === (128'h1 << fvec)), 32'h1);
      end
   end

   initial begin
      #500000;
      fails++;
      test_done;
   end

   initial begin
      rst = 1'b1;
      rq = '0;
      rng = 32'hC7D1A8C7;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 32; a += 4) rchk("reset", 8'(a), 32'h0);
      wr(8'h1C, 32'hFFFFFFFF);
      rchk("unmapped", 8'h1C, 32'h0);
      for (int i = 0; i < 4; i++) begin
         rnd(d);
         wr(8'(4 * i), d);
         rchk("enable", 8'(4 * i), d);
         wr(8'(4 * i), 32'h0);
      end
      // software start, count not ended, no interrupt: flag drops
      rnd(d);
      v = d[6:0];
      u_mem.put(vad(24'h0, v), 32'h0100, 2);
      desc(24'hFF0100, 8'h80, 8'h00, 24'h001000, 24'h002000, 16'h2, 16'h0);
      u_mem.put(24'h001000, d[31:24], 1);
      wr(xfer_pkg::REG_SOFT, {24'h0, 1'b1, v});
      wait_ev(0);
      check("byte", u_mem.get(24'h002000, 1), {24'h0, d[31:24]});
      check("src wb", u_mem.get(24'hFF0100, 4), 32'h80001001);
      check("dst wb", u_mem.get(24'hFF0104, 4), 32'h00002000);
      check("cnt wb", u_mem.get(24'hFF0108, 4), 32'h00010000);
      rchk("flag off", xfer_pkg::REG_SOFT, {25'h0, v});
      // moved table, word unit, last transfer: flag kept and forwarded
      wr(xfer_pkg::REG_VECTOR_OFFSET_REGISTER, 32'h000200);
      u_mem.put(vad(24'h000200, v), 32'h0140, 2);
      desc(24'hFF0140, 8'h81, 8'h00, 24'h001000, 24'h002002, 16'h1, 16'h0);
      u_mem.put(24'h001000, d[15:0], 2);
      wr(xfer_pkg::REG_SOFT, {24'h0, 1'b1, v});
      wait_ev(1);
      check("soft fwd", evq.pop_front(), {22'h0, 2'h2, 1'b1, v});
      check("word", u_mem.get(24'h002002, 2), {16'h0, d[15:0]});
      rchk("flag on", xfer_pkg::REG_SOFT, {24'h0, 1'b1, v});
      wr(xfer_pkg::REG_VECTOR_OFFSET_REGISTER, 32'h0);
      wr(xfer_pkg::REG_SOFT, 32'h0);
      // a request whose enable is off starts nothing
      u_mem.raise(110);
      repeat (60) @(posedge clk);
      check("idle", {31'h0, busy}, 32'h0);
      wait_ev(0);
      u_mem.drop(110);
      // timer g match a: first pass clears the peripheral, second ends
      u_mem.put(24'h0004DA, 32'h0180, 2);
      desc(24'hFF0180, 8'h80, 8'h00, 24'h001000, 24'h002004, 16'h2, 16'h0);
      wr(xfer_pkg::REG_EN3, 32'h00002000);
      u_mem.raise(109);
      wait_ev(1);
      check("periph clr", evq.pop_front(), 32'h0000016D);
      rchk("en kept", xfer_pkg::REG_EN3, 32'h00002000);
      check("cnt wb", u_mem.get(24'hFF0188, 4), 32'h00010000);
      u_mem.raise(109);
      wait_ev(1);
      check("irq fwd", evq.pop_front(), 32'h0000026D);
      rchk("en off", xfer_pkg::REG_EN3, 32'h0);
      check("flag kept", {31'h0, irq[109]}, 32'h1);
      u_mem.drop(109);
      // random requests with every enable off start nothing
      for (int i = 0; i < 8; i++) begin
         rnd(d);
         u_mem.raise(d[6:0]);
      end
      repeat (20) @(posedge clk);
      check("masked", {31'h0, busy}, 32'h0);
      // a reset in mid-run stops the engine and clears the enables
      wr(xfer_pkg::REG_EN3, 32'h00002000);
      u_mem.raise(109);
      repeat (6) @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      u_mem.flags <= '0;
      repeat (2) @(negedge clk);
      check("reset busy", {31'h0, busy}, 32'h0);
      rchk("reset en", xfer_pkg::REG_EN3, 32'h0);
      wait_ev(0);
      // 256-byte block, source is block area; others queue meanwhile
      for (int i = 0; i < 256; i++) begin
         rnd(d);
         u_mem.put(24'h005000 + 24'(i), d[7:0], 1);
      end
      u_mem.put(vad(24'h0, 7'd2), 32'h01C0, 2);
      desc(24'hFF01C0, 8'hAA, 8'h40, 24'h005000, 24'hA06000, 16'h0, 16'h2);
      // one chain of two consecutive descriptors for vectors 3, 5, 20
      u_mem.put(vad(24'h0, 7'd3), 32'h0200, 2);
      u_mem.put(vad(24'h0, 7'd5), 32'h0200, 2);
      u_mem.put(vad(24'h0, 7'd20), 32'h0200, 2);
      desc(24'hFF0200, 8'hA0, 8'hC0, 24'h005000, 24'h004000, 16'h100, 16'h0);
      desc(24'hFF020C, 8'hA0, 8'h40, 24'h005010, 24'h004010, 16'h100, 16'h0);
      wr(xfer_pkg::REG_EN0, 32'h00000004);
      u_mem.raise(2);
      repeat (20) @(posedge clk);
      wr(xfer_pkg::REG_EN0, 32'h00100024);
      wr(xfer_pkg::REG_SOFT, 32'h00000083);
      u_mem.raise(20);
      u_mem.raise(5);
      wait_ev(4);
      check("first", evq.pop_front(), 32'h00000202);
      check("soft", evq.pop_front(), 32'h00000283);
      check("low", evq.pop_front(), 32'h00000205);
      check("high", evq.pop_front(), 32'h00000214);
      for (int i = 0; i < 256; i++)
         check("block", u_mem.get(24'hA06000 + 24'(i), 1),
               u_mem.get(24'h005000 + 24'(i), 1));
      check("blk cnt", u_mem.get(24'hFF01C8, 4), 32'h00000001);
      check("blk src", u_mem.get(24'hFF01C0, 4), 32'hAA005000);
      check("blk dst", u_mem.get(24'hFF01C4, 4), 32'h40A06100);
      check("chain a", u_mem.get(24'h004002, 1),
            u_mem.get(24'h005002, 1));
      check("chain b", u_mem.get(24'h004012, 1),
            u_mem.get(24'h005012, 1));
      check("chain cnt", u_mem.get(24'hFF0208, 4), 32'h00FD0000);
      // repeat mode, two-unit source area, falling destination
      u_mem.put(vad(24'h0, 7'd7), 32'h0240, 2);
      desc(24'hFF0240, 8'hB6, 8'h00, 24'h005000, 24'h003000, 16'h0202,
           16'h0);
      for (int i = 0; i < 2; i++) begin
         wr(xfer_pkg::REG_SOFT, 32'h00000087);
         wait_ev(0);
      end
      check("rpt src", u_mem.get(24'hFF0240, 4), 32'hB6005000);
      check("rpt dst", u_mem.get(24'hFF0244, 4), 32'h00002FFE);
      check("rpt cnt", u_mem.get(24'hFF0248, 4), 32'h02020000);
      check("rpt data", u_mem.get(24'h002FFF, 1),
            u_mem.get(24'h005001, 1));
      rchk("rpt flag", xfer_pkg::REG_SOFT, 32'h00000007);
      test_done;
   end
endmodule // event_transfer_engine_test
`default_nettype wire
